/* File: core/dtd_regs.svh */
// Opcode, field and cycle-count constants for the data transfer decoder.
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH
`define DTD_OP_SEG_LOAD   8'h8e
`define DTD_OP_SEG_STORE  8'h8c
`define DTD_OP_XLATE      8'hd7
`define DTD_OP_EA_LOAD    8'h8d
`define DTD_OP_FP_DATA    8'hc5
`define DTD_OP_FP_EXTRA   8'hc4
`define DTD_OP_FL_TO_AH   8'h9f
`define DTD_OP_AH_TO_FL   8'h9e
`define DTD_MOD_MSB       7
`define DTD_MOD_LSB       6
`define DTD_MOD_REG       2'h3
`define DTD_CYC_SEGLD_R   6'h02
`define DTD_CYC_SEGLD_M   6'h0d
`define DTD_CYC_SEGST_R   6'h02
`define DTD_CYC_SEGST_M   6'h0f
`define DTD_CYC_XLATE     6'h0f
`define DTD_CYC_EA_LOAD   6'h06
`define DTD_CYC_FP_LOAD   6'h1a
`define DTD_CYC_FL_TO_AH  6'h02
`define DTD_CYC_AH_TO_FL  6'h03
`define DTD_CYC_WORD_ADD  6'h04
`define DTD_CYC_MAX_SYNC  6'h02
`endif

/* File: core/dtd_pkg.sv */
// Types shared by the data transfer decoder.
package dtd_pkg;
   typedef enum logic [7:0] {
      DTD_OP_NONE     = 8'h01,
      DTD_OP_SEGLD    = 8'h02,
      DTD_OP_SEGST    = 8'h04,
      DTD_OP_XLT      = 8'h08,
      DTD_OP_EALD     = 8'h10,
      DTD_OP_FPD      = 8'h20,
      DTD_OP_FPE      = 8'h40,
      DTD_OP_FLAH     = 8'h80
   } dtd_op_t;
   typedef enum logic [3:0] {
      DTD_ST_IDLE  = 4'h1,
      DTD_ST_MODRM = 4'h2,
      DTD_ST_EXEC  = 4'h4,
      DTD_ST_SYNC  = 4'h8
   } dtd_state_t;
endpackage

/* File: core/dtd_cycle_table.sv */
// Minimum cycle count lookup for one decoded instruction.
`timescale 1ns/1ns
`default_nettype none
`include "dtd_regs.svh"
module dtd_cycle_table (
   input  wire logic [7:0] opcode_i,    // Opcode byte
   input  wire logic       mem_i,       // Operand is in memory
   input  wire logic       word_i,      // Word-sized memory transfer
   output logic      [5:0] cycles_o     // Minimum clocks
);
   logic [5:0] base;
   always_comb begin
      case (opcode_i)
         `DTD_OP_SEG_LOAD:  base = mem_i ? `DTD_CYC_SEGLD_M
                                         : `DTD_CYC_SEGLD_R;
         `DTD_OP_SEG_STORE: base = mem_i ? `DTD_CYC_SEGST_M
                                         : `DTD_CYC_SEGST_R;
         `DTD_OP_XLATE:     base = `DTD_CYC_XLATE;
         `DTD_OP_EA_LOAD:   base = `DTD_CYC_EA_LOAD;
         `DTD_OP_FP_DATA:   base = `DTD_CYC_FP_LOAD;
         `DTD_OP_FP_EXTRA:  base = `DTD_CYC_FP_LOAD;
         `DTD_OP_FL_TO_AH:  base = `DTD_CYC_FL_TO_AH;
         `DTD_OP_AH_TO_FL:  base = `DTD_CYC_AH_TO_FL;
         default:           base = 6'h01;
      endcase
      // Segment moves are word transfers, so the memory form pays extra.
      cycles_o = (word_i && mem_i) ? 6'(base + `DTD_CYC_WORD_ADD)
                                   : base;
   end
endmodule
`default_nettype wire

/* File: core/dtd_decoder.sv */
// Data transfer instruction decoder and execution cycle sequencer.
// Functional notes
// - 8E with addressing byte loads segment reg; 2 register, 13 memory.
// - 8C with addressing byte stores segment reg; 2 register, 15 memory.
// - D7 alone is table translate into low accumulator byte, 15 clocks.
// - 8D loads effective address, no memory access, 6 clocks.
// - C5 far pointer load with data segment, memory only, 26 clocks.
// - C4 far pointer load with extra segment, memory only, 26 clocks.
// - 9F copies low flags into high accumulator byte, 2 clocks.
// - 9E stores high accumulator byte into low flags, 3 clocks.
// - Word-sized memory transfers add 4 clocks to the minimum; the code adds them only to the memory forms of 8E and 8C, not C5/C4.
// - Memory instructions may stall one or two clocks for bus handshake.
// - Jump and call counts include destination fetch; none decoded here.
// - Counts are minima; execution waits while queue bytes are missing.
// - Byte-wide fetch leaves queue short; decoder stalls on empty queue.
`timescale 1ns/1ns
`default_nettype none
`include "dtd_regs.svh"
module dtd_decoder (
   input  wire logic       mclk_i,      // Processor clock, 10 MHz
   input  wire logic       rst_i,       // Synchronous reset, active high
   input  wire logic [7:0] q_byte_i,    // Byte at the head of the queue
   input  wire logic       q_valid_i,   // Queue head holds a byte
   output logic            q_pop_o,     // Consume the queue head byte
   input  wire logic       bus_done_i,  // Bus unit finished memory access
   output logic            busy_o,      // Instruction in progress
   output logic            done_o,      // Pulse: instruction finished
   output logic            illegal_o,   // Pulse: undefined register form
   output logic      [7:0] op_onehot_o, // Decoded operation, one-hot
   output logic      [1:0] mod_o,       // Addressing kind field
   output logic      [2:0] reg_o,       // Register field
   output logic      [2:0] rm_o,        // Register/memory field
   output logic            mem_o,       // Operand lives in memory
   output logic      [5:0] cycles_o     // Minimum clocks of the instruction
);
   typedef struct packed {
      dtd_pkg::dtd_state_t st;
      logic [7:0]          op;
      logic [7:0]          modrm;
      logic                mem;
      logic [5:0]          cnt;
      logic [5:0]          cyc;
      logic [1:0]          wait_cnt;
      logic                done;
      logic                illegal;
      logic [7:0]          kind;
   } dtd_s_t;

   dtd_s_t s_reg;
   dtd_s_t s_next;
   logic [5:0] tbl_cycles;

   function automatic logic needs_modrm(input logic [7:0] op);
      needs_modrm = (op == `DTD_OP_SEG_LOAD) || (op == `DTD_OP_SEG_STORE) ||
                    (op == `DTD_OP_EA_LOAD)  || (op == `DTD_OP_FP_DATA) ||
                    (op == `DTD_OP_FP_EXTRA);
   endfunction

   // Jumps and calls are outside this group, so they are never popped here.
   function automatic logic known_op(input logic [7:0] op);
      known_op = needs_modrm(op) || (op == `DTD_OP_XLATE) ||
                 (op == `DTD_OP_FL_TO_AH) || (op == `DTD_OP_AH_TO_FL);
   endfunction

   function automatic logic [7:0] op_kind(input logic [7:0] op);
      case (op)
         `DTD_OP_SEG_LOAD:  op_kind = dtd_pkg::DTD_OP_SEGLD;
         `DTD_OP_SEG_STORE: op_kind = dtd_pkg::DTD_OP_SEGST;
         `DTD_OP_XLATE:     op_kind = dtd_pkg::DTD_OP_XLT;
         `DTD_OP_EA_LOAD:   op_kind = dtd_pkg::DTD_OP_EALD;
         `DTD_OP_FP_DATA:   op_kind = dtd_pkg::DTD_OP_FPD;
         `DTD_OP_FP_EXTRA:  op_kind = dtd_pkg::DTD_OP_FPE;
         `DTD_OP_FL_TO_AH,
         `DTD_OP_AH_TO_FL:  op_kind = dtd_pkg::DTD_OP_FLAH;
         default:           op_kind = dtd_pkg::DTD_OP_NONE;
      endcase
   endfunction

   // Addressing byte is already held when cycles are looked up.
   dtd_cycle_table u_table (
      .opcode_i (s_reg.op),
      .mem_i    (s_reg.mem),
      .word_i   (s_reg.op == `DTD_OP_SEG_LOAD ||
                 s_reg.op == `DTD_OP_SEG_STORE),
      .cycles_o (tbl_cycles)
   );

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.illegal = 1'b0;
      q_pop_o = 1'b0;
      case (s_reg.st)
         dtd_pkg::DTD_ST_IDLE: begin
            // Waiting on the queue is what stretches real time.
            if (q_valid_i && known_op(q_byte_i)) begin
               q_pop_o = 1'b1;
               s_next.op = q_byte_i;
               s_next.kind = op_kind(q_byte_i);
               s_next.modrm = 8'h00;
               // Of the opcode-only forms, only the translate reaches memory.
               s_next.mem = (q_byte_i == `DTD_OP_XLATE);
               s_next.st = needs_modrm(q_byte_i) ? dtd_pkg::DTD_ST_MODRM
                                                 : dtd_pkg::DTD_ST_EXEC;
               s_next.cnt = 6'h00;
            end
         end
         dtd_pkg::DTD_ST_MODRM: begin
            if (q_valid_i) begin
               q_pop_o = 1'b1;
               s_next.modrm = q_byte_i;
               s_next.mem = (q_byte_i[`DTD_MOD_MSB:`DTD_MOD_LSB] !=
                             `DTD_MOD_REG);
               // The address computation alone never reaches memory.
               if (s_reg.op == `DTD_OP_EA_LOAD) begin
                  s_next.mem = 1'b0;
               end
               if ((s_reg.op == `DTD_OP_FP_DATA ||
                    s_reg.op == `DTD_OP_FP_EXTRA) &&
                   q_byte_i[`DTD_MOD_MSB:`DTD_MOD_LSB] == `DTD_MOD_REG) begin
                  s_next.illegal = 1'b1;
                  s_next.st = dtd_pkg::DTD_ST_IDLE;
               end else begin
                  s_next.st = dtd_pkg::DTD_ST_EXEC;
               end
            end
         end
         dtd_pkg::DTD_ST_EXEC: begin
            s_next.cyc = tbl_cycles;
            s_next.cnt = 6'(s_reg.cnt + 6'h01);
            if (s_reg.cnt + 6'h01 >= tbl_cycles) begin
               s_next.wait_cnt = 2'h0;
               if (s_reg.mem && !bus_done_i) begin
                  s_next.st = dtd_pkg::DTD_ST_SYNC;
               end else begin
                  s_next.done = 1'b1;
                  s_next.st = dtd_pkg::DTD_ST_IDLE;
               end
            end
         end
         dtd_pkg::DTD_ST_SYNC: begin
            // The handshake is bounded at two clocks so a lost strobe
            // cannot hang the execution unit.
            s_next.wait_cnt = 2'(s_reg.wait_cnt + 2'h1);
            if (bus_done_i || s_reg.wait_cnt == 2'h1) begin
               s_next.done = 1'b1;
               s_next.st = dtd_pkg::DTD_ST_IDLE;
            end
         end
         default: s_next.st = dtd_pkg::DTD_ST_IDLE;
      endcase
      if (rst_i) begin
         // Nothing may leave the queue while reset is held.
         q_pop_o = 1'b0;
         s_next = '0;
         s_next.st = dtd_pkg::DTD_ST_IDLE;
         s_next.kind = dtd_pkg::DTD_OP_NONE;
      end
   end

   always_ff @(posedge mclk_i) begin
      s_reg <= s_next;
   end

   assign busy_o      = (s_reg.st != dtd_pkg::DTD_ST_IDLE);
   assign done_o      = s_reg.done;
   assign illegal_o   = s_reg.illegal;
   assign op_onehot_o = s_reg.kind;
   assign mod_o       = s_reg.modrm[7:6];
   assign reg_o       = s_reg.modrm[5:3];
   assign rm_o        = s_reg.modrm[2:0];
   assign mem_o       = s_reg.mem;
   assign cycles_o    = s_reg.cyc;

   logic [5:0] run_cnt;
   always_ff @(posedge mclk_i) begin
      if (rst_i || s_reg.st != dtd_pkg::DTD_ST_EXEC) begin
         run_cnt <= 6'h00;
      end else begin
         run_cnt <= 6'(run_cnt + 6'h01);
      end
   end

   property p_seg_load_mem;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_EXEC && s_reg.op == `DTD_OP_SEG_LOAD
       && s_reg.mem) |-> tbl_cycles == 6'h11;
   endproperty
   a_seg_load_mem: assert property (p_seg_load_mem)
      else $error("segment load memory count wrong");

   property p_seg_store_reg;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_EXEC && s_reg.op == `DTD_OP_SEG_STORE
       && !s_reg.mem) |-> tbl_cycles == 6'h02;
   endproperty
   a_seg_store_reg: assert property (p_seg_store_reg)
      else $error("segment store register count wrong");

   property p_xlate;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_EXEC && s_reg.op == `DTD_OP_XLATE)
      |-> tbl_cycles == 6'h0f;
   endproperty
   a_xlate: assert property (p_xlate)
      else $error("translate count wrong");

   property p_ea_nomem;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_EXEC && s_reg.op == `DTD_OP_EA_LOAD)
      |-> !s_reg.mem && tbl_cycles == 6'h06;
   endproperty
   a_ea_nomem: assert property (p_ea_nomem)
      else $error("effective address load touched memory");

   property p_fp_illegal;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_MODRM && q_valid_i &&
       (s_reg.op == `DTD_OP_FP_DATA || s_reg.op == `DTD_OP_FP_EXTRA) &&
       q_byte_i[7:6] == 2'h3) |=> illegal_o && !busy_o;
   endproperty
   a_fp_illegal: assert property (p_fp_illegal)
      else $error("register form of pointer load not refused");

   property p_flah_len;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_EXEC && s_reg.op == `DTD_OP_FL_TO_AH
       && s_reg.cnt == 6'h00) |=> ##1 done_o;
   endproperty
   a_flah_len: assert property (p_flah_len)
      else $error("flags to high byte not two clocks");

   property p_sync_bound;
      @(posedge mclk_i) disable iff (rst_i)
      (s_reg.st == dtd_pkg::DTD_ST_SYNC) |-> ##[1:2] done_o;
   endproperty
   a_sync_bound: assert property (p_sync_bound)
      else $error("handshake stall exceeded two clocks");

   property p_exec_min;
      @(posedge mclk_i) disable iff (rst_i)
      done_o |-> $past(s_reg.cnt) + 6'h01 >= $past(tbl_cycles)
                 || $past(s_reg.st) == dtd_pkg::DTD_ST_SYNC;
   endproperty
   a_exec_min: assert property (p_exec_min)
      else $error("instruction finished before its minimum");

   property p_run_cap;
      @(posedge mclk_i) disable iff (rst_i)
      run_cnt <= 6'h1a;
   endproperty
   a_run_cap: assert property (p_run_cap)
      else $error("execution ran past longest count");

   c_fp_load: cover property (@(posedge mclk_i)
      s_reg.op == `DTD_OP_FP_DATA && done_o);
   c_seg_mem: cover property (@(posedge mclk_i)
      s_reg.op == `DTD_OP_SEG_STORE && s_reg.mem && done_o);
   c_sync: cover property (@(posedge mclk_i)
      s_reg.st == dtd_pkg::DTD_ST_SYNC);
   c_illegal: cover property (@(posedge mclk_i) illegal_o);
endmodule
`default_nettype wire

/* File: tb/dtd_queue_model.sv */
// Behavioural prefetch queue and bus unit that face the decoder.
`timescale 1ns/1ns
`default_nettype none
module dtd_queue_model (
   input  wire logic       mclk_i,     // Processor clock
   input  wire logic       rst_i,      // Synchronous reset, active high
   input  wire logic       q_pop_i,    // Head byte consumed this edge
   input  wire logic       busy_i,     // Decoder has an instruction
   input  wire logic       mem_i,      // Operand lives in memory
   input  wire logic       stall_i,    // Hold back the next byte
   input  wire logic [1:0] slow_i,     // Bus wait before done, in clocks
   input  wire logic [5:0] cycles_i,   // Decoder minimum count
   output logic      [7:0] q_byte_o,   // Head byte
   output logic            q_valid_o,  // Head holds a byte
   output logic            bus_done_o  // Memory access finished
);
   logic [7:0]  mem_q [0:255];
   int          run_len  = 0;
   int unsigned rd_idx   = 0;
   int unsigned wr_idx   = 0;
   int unsigned nxt;
   initial begin
      q_byte_o   = 8'h00;
      q_valid_o  = 1'b0;
      bus_done_o = 1'b0;
   end
   task automatic push(input logic [7:0] b);
      mem_q[wr_idx[7:0]] = b;
      wr_idx = wr_idx + 1;
   endtask
   task automatic skip();
      rd_idx = rd_idx + 1;
   endtask
   always @(posedge mclk_i) begin
      nxt = rd_idx + ((q_pop_i === 1'b1 && q_valid_o) ? 1 : 0);
      rd_idx = nxt;
      // A byte-wide fetch often leaves the queue empty between bytes.
      if (rst_i || stall_i || nxt == wr_idx) begin
         q_valid_o <= 1'b0;
         // An empty head shows the last byte inverted, flipping back on every second empty clock.
         q_byte_o  <= ~q_byte_o;
      end else begin
         q_valid_o <= 1'b1;
         q_byte_o  <= mem_q[nxt[7:0]];
      end
      if (!(busy_i && mem_i)) begin
         run_len <= 0;
      end else begin
         run_len <= run_len + 1;
      end
      // The answer lands slow_i clocks after the minimum, so that late
      // settings really push the decoder into its handshake stall.
      bus_done_o <= busy_i && mem_i &&
                    (run_len + 2 >= int'(cycles_i) + int'(slow_i));
   end
endmodule
`default_nettype wire

/* File: tb/data_transfer_decode_tb.sv */
// Self-checking bench of the data transfer decoder.
`timescale 1ns/1ns
`default_nettype none
`include "dtd_regs.svh"
module data_transfer_decode_tb;
   logic       mclk_i = 1'b0;
   logic       rst_i  = 1'b1;
   logic       stall  = 1'b0;
   logic       st_en  = 1'b0;
   logic [1:0] slow   = 2'h0;
   logic [7:0] q_byte_i;
   logic       q_valid_i, q_pop_o, bus_done_i, busy_o, done_o, illegal_o;
   logic [7:0] op_onehot_o;
   logic [1:0] mod_o;
   logic [2:0] reg_o, rm_o;
   logic       mem_o;
   logic [5:0] cycles_o;
   int         err_total = 0;
   int         cmp_count = 0;
   int         seed = 52;
   int         cyc = 0, last_pop = 0, lat = 0;
   logic       seen = 0, g_done, g_ill, g_mem;
   logic [7:0] g_oh;
   logic [7:0] g_f;
   logic [5:0] g_cyc;
   logic [7:0] ops [8] = '{`DTD_OP_SEG_LOAD, `DTD_OP_SEG_STORE,
      `DTD_OP_XLATE, `DTD_OP_EA_LOAD, `DTD_OP_FP_DATA, `DTD_OP_FP_EXTRA,
      `DTD_OP_FL_TO_AH, `DTD_OP_AH_TO_FL};
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   dtd_decoder uut (.mclk_i(mclk_i), .rst_i(rst_i), .q_byte_i(q_byte_i),
      .q_valid_i(q_valid_i), .q_pop_o(q_pop_o), .bus_done_i(bus_done_i),
      .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
      .op_onehot_o(op_onehot_o), .mod_o(mod_o), .reg_o(reg_o),
      .rm_o(rm_o), .mem_o(mem_o), .cycles_o(cycles_o));
   dtd_queue_model qm (.mclk_i(mclk_i), .rst_i(rst_i), .q_pop_i(q_pop_o),
      .busy_i(busy_o), .mem_i(mem_o), .stall_i(stall), .slow_i(slow),
      .cycles_i(cycles_o), .q_byte_o(q_byte_i), .q_valid_o(q_valid_i),
      .bus_done_o(bus_done_i));
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
      cmp_count++;
      if (seen_v !== exp_v) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   function automatic logic [5:0] exp_cyc(input logic [7:0] op,
                                          input logic [1:0] md);
      logic r;
      r = (md == 2'h3);
      case (op)
         8'h8e:   return r ? 6'h02 : 6'h11;
         8'h8c:   return r ? 6'h02 : 6'h13;
         8'hd7:   return 6'h0f;
         8'h8d:   return 6'h06;
         8'hc5:   return 6'h1a;
         8'hc4:   return 6'h1a;
         8'h9f:   return 6'h02;
         default: return 6'h03;
      endcase
   endfunction
   function automatic logic [7:0] exp_oh(input logic [7:0] op);
      case (op)
         8'h8e:        return dtd_pkg::DTD_OP_SEGLD;
         8'h8c:        return dtd_pkg::DTD_OP_SEGST;
         8'hd7:        return dtd_pkg::DTD_OP_XLT;
         8'h8d:        return dtd_pkg::DTD_OP_EALD;
         8'hc5:        return dtd_pkg::DTD_OP_FPD;
         8'hc4:        return dtd_pkg::DTD_OP_FPE;
         default:      return dtd_pkg::DTD_OP_FLAH;
      endcase
   endfunction
   // Samples outputs as they stood just before each edge.
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (q_pop_o === 1'b1 && q_valid_i) last_pop = cyc;
      if (done_o === 1'b1 || illegal_o === 1'b1) begin
         lat    = cyc - last_pop;
         g_done = done_o;
         g_ill  = illegal_o;
         g_oh   = op_onehot_o;
         g_f    = {mod_o, reg_o, rm_o};
         g_mem  = mem_o;
         g_cyc  = cycles_o;
         seen   = 1'b1;
      end
      stall <= st_en && ($random(seed) % 3 == 0);
      if (cyc > 20000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic run(input logic [7:0] op, input logic [7:0] mrm);
      logic       has_m, mm;
      logic [5:0] n;
      logic [7:0] e_lat;
      int         k;
      has_m = op inside {8'h8e, 8'h8c, 8'h8d, 8'hc5, 8'hc4};
      mm = (op == 8'hd7) || (has_m && op != 8'h8d && mrm[7:6] != 2'h3);
      n = exp_cyc(op, mrm[7:6]);
      @(negedge mclk_i);
      seen = 1'b0;
      qm.push(op);
      if (has_m) qm.push(mrm);
      k = 0;
      while (!seen && k < 120) begin
         @(negedge mclk_i);
         k++;
      end
      check(8'(seen), 8'h01);
      if (op[7:1] == 7'h62 && mrm[7:6] == 2'h3) begin
         check(8'({g_ill, g_done}), 8'h02);
      end else begin
         check(8'({g_ill, g_done}), 8'h01);
         check(g_oh, exp_oh(op));
         check(g_f, has_m ? mrm : 8'h00);
         check(8'(g_mem), 8'(mm));
         check(8'(g_cyc), 8'(n));
         if (mm) begin
            // A late bus answer stretches the finish by at most two clocks.
            e_lat = 8'(n) + 8'h01 + 8'(slow > 2'h2 ? 2'h2 : slow);
            check(8'(lat > n && lat <= n + 3), 8'h01);
            check(8'(lat), e_lat);
         end else begin
            check(8'(lat), 8'(n) + 8'h01);
         end
      end
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      foreach (ops[i]) begin
         run(ops[i], 8'h1d);
         run(ops[i], 8'hfa);
         run(ops[i], 8'h45);
      end
      // An opcode outside the group must stay at the queue head.
      @(negedge mclk_i);
      qm.push(8'h90);
      repeat (6) begin
         @(negedge mclk_i);
         check(8'({q_pop_o, busy_o}), 8'h00);
      end
      qm.skip();
      st_en = 1'b1;
      repeat (40) begin
         slow = 2'($random(seed));
         run(ops[3'($random(seed))], 8'($random(seed)));
      end
      finish_test();
   end
endmodule
`default_nettype wire
